// ### rtl/dbs_top.sv
// Supervisor and sequencer of a dual step-down converter.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "dbs_consts.svh"
module dbs_top #(
	parameter int PG_DELAY_CYCLES = `DBS_PG_DELAY_CYCLES,
	parameter int RAMP_W = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Analog comparator results.
	input wire logic enable_in,
	input wire logic input_undervoltage_lockout,
	input wire logic temp_over_180,
	input wire logic temp_below_140,
	input wire logic [1:0] in_reg,
	input wire logic [1:0] short_det,
	// Mode/sync pin.
	input wire logic mode_pin,
	// Converter control.
	output logic [1:0] conv_en,
	output logic [1:0] min_duty,
	output logic [1:0] ref_regular,
	output logic [RAMP_W-1:0] ramp0,
	output logic [RAMP_W-1:0] ramp1,
	output logic ref_on,
	output logic osc_on,
	output dbs_pkg::dbs_mode_t sw_mode,
	output logic sync_pulse,
	// Open-drain reset pin.
	output logic rst_pin_o,
	output logic rst_pin_oe,
	// AXI4-Lite write channels.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import dbs_pkg::*;

	// ****************
	// Declarations
	// ****************

	// Counter wide enough to hold the full release delay.
	localparam int PGW = $clog2(PG_DELAY_CYCLES + 1);
	localparam logic [PGW-1:0] PG_LAST = PGW'(PG_DELAY_CYCLES);
	// Bus response codes: okay and slave error.
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	dbs_state_t state_r; // Sequencer state.
	dbs_state_t state_nxt; // Its next value.
	logic [1:0] ch_en_r; // Software channel enables.
	logic [PGW-1:0] pg_cnt_r; // Release delay counter.
	logic pg_r; // Reset pin released.
	dbs_ch_stat_t st0; // Channel 0 status.
	dbs_ch_stat_t st1; // Channel 1 status.

	// Write path holding registers.
	logic aw_have_r;
	logic w_have_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	// ****************
	// Sequencer
	// ****************

	// Converters may only switch while starting or running.
	// Lockout and thermal states stop every channel, which also
	// restarts each soft-start ramp from zero on the way back.
	wire powered = (state_r == DBS_ST_SOFTSTART) || (state_r == DBS_ST_RUN);

	// A channel runs only if software enabled it.
	wire [1:0] ch_start = {2{powered}} & ch_en_r;

	// Soft-start done once every enabled channel has ramped.
	wire all_ramped = (!ch_en_r[0] || st0.ss_done) && (!ch_en_r[1] || st1.ss_done);

	// Next state; enable low beats every other condition.
	always_comb begin
		state_nxt = state_r;
		// Every legal state is named below; the default only catches
		// a corrupted one-hot code and parks the sequencer in shutdown.
		unique case (state_r)
			DBS_ST_SHUTDOWN: begin
				if (enable_in) begin
					state_nxt = DBS_ST_LOCKOUT;
				end
			end
			DBS_ST_LOCKOUT: begin
				if (input_undervoltage_lockout) begin
					state_nxt = DBS_ST_SOFTSTART;
				end
			end
			DBS_ST_SOFTSTART: begin
				if (!input_undervoltage_lockout) begin
					state_nxt = DBS_ST_LOCKOUT;
				end else if (all_ramped) begin
					state_nxt = DBS_ST_RUN;
				end
			end
			DBS_ST_RUN: begin
				if (!input_undervoltage_lockout) begin
					state_nxt = DBS_ST_LOCKOUT;
				end
			end
			DBS_ST_THERMAL: begin
				if (temp_below_140) begin
					state_nxt = DBS_ST_LOCKOUT;
				end
			end
			default: begin
				state_nxt = DBS_ST_SHUTDOWN;
			end
		endcase
		// Thermal trip overrides all but shutdown.
		if (temp_over_180 && state_r != DBS_ST_SHUTDOWN) begin
			state_nxt = DBS_ST_THERMAL;
		end
		if (!enable_in) begin
			state_nxt = DBS_ST_SHUTDOWN;
		end
	end

	// State register.
	// Reset lands in shutdown, so nothing switches before enable.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= DBS_ST_SHUTDOWN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Reference and oscillator follow enable; thermal stops them too.
	// Both follow the next state, so they drop on the same edge as
	// the state register rather than one cycle later.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ref_on <= 1'b0;
			osc_on <= 1'b0;
		end else begin
			ref_on <= (state_nxt != DBS_ST_SHUTDOWN) && (state_nxt != DBS_ST_THERMAL);
			osc_on <= (state_nxt != DBS_ST_SHUTDOWN) && (state_nxt != DBS_ST_THERMAL);
		end
	end

	// ****************
	// Channels
	// ****************

	// Each channel ramps on its own, so a late enable gets its own soft-start.
	dbs_ch_ctrl #(
		.RAMP_W(RAMP_W)
	) u_ch0 (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(ch_start[0]),
		.short_det(short_det[0]),
		.ramp(ramp0),
		.stat(st0)
	);

	dbs_ch_ctrl #(
		.RAMP_W(RAMP_W)
	) u_ch1 (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(ch_start[1]),
		.short_det(short_det[1]),
		.ramp(ramp1),
		.stat(st1)
	);

	// Flattened channel outputs, one flop stage from the helpers.
	// The converter pins therefore lag the helper state by one clock,
	// which keeps every top-level output straight from a flop.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			conv_en <= 2'h0;
			min_duty <= 2'h0;
			ref_regular <= 2'h0;
		end else begin
			conv_en <= {st1.conv_en, st0.conv_en};
			min_duty <= {st1.min_duty, st0.min_duty};
			ref_regular <= {st1.ss_done, st0.ss_done};
		end
	end

	// ****************
	// Mode decode
	// ****************

	// The detector is never held off by enable, so a sync clock applied
	// before enable is already locked when the converters start.
	dbs_sync_det u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.mode_pin(mode_pin),
		.mode(sw_mode),
		.sync_pulse(sync_pulse)
	);

	// ****************
	// Power-good reset
	// ****************

	// With both channels disabled there is nothing to supervise, so the
	// reset pin is held low rather than released on no evidence.
	// A disabled channel counts as good; an enabled one must have
	// finished its ramp and be above the regulation comparator.
	wire ch0_good = !ch_en_r[0] || (st0.ss_done && in_reg[0]);
	wire ch1_good = !ch_en_r[1] || (st1.ss_done && in_reg[1]);
	wire all_good = powered && (ch_en_r != 2'h0) && ch0_good && ch1_good;

	// The delay counts reference clocks, so it scales with the oscillator.
	// The counter stops at the delay value and clears whenever all_good
	// drops, so a long run never wraps it.
	always_ff @(posedge ref_clk) begin
		if (rst || !all_good) begin
			pg_cnt_r <= '0;
			pg_r <= 1'b0;
		end else if (pg_cnt_r != PG_LAST) begin
			pg_cnt_r <= pg_cnt_r + 1'b1;
			pg_r <= 1'b0;
		end else begin
			pg_r <= 1'b1;
		end
	end

	// Only ever pull low; the high level comes from the pull-up.
	// The pin lags the counter by one flop, which keeps it glitch-free
	// at the cost of one clock of extra delay.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rst_pin_o <= 1'b0;
			rst_pin_oe <= 1'b1;
		end else begin
			rst_pin_o <= 1'b0;
			rst_pin_oe <= !pg_r;
		end
	end

	// ****************
	// AXI4-Lite slave
	// ****************

	// Limitation: one write and one read at a time; the readies stay
	// low from acceptance until the response has been taken.
	// Address and data may arrive in either order; each is held here.
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	wire wr_hit = (aw_addr_r == `DBS_OFS_CTRL);
	wire wr_ok = wr_hit || (aw_addr_r == `DBS_OFS_STATUS) || (aw_addr_r == `DBS_OFS_COUNT);

	// Write channel capture and response.
	// Writes to the read-only registers are answered okay and ignored.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
			ch_en_r <= `DBS_CTRL_RST;
		end else begin
			if (aw_take) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_take) begin
				w_have_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OK : RESP_ERR;
				if (wr_hit && w_strb_r[0]) begin
					ch_en_r <= w_data_r[1:0];
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read decode; status and counter are read-only views.
	wire [31:0] sts_word = {20'h0, st1.ss_done, st0.ss_done, sw_mode, in_reg, pg_r, state_r};
	wire [31:0] cnt_word = 32'(pg_cnt_r);
	wire rd_ctrl = (s_axi_araddr == `DBS_OFS_CTRL);
	wire rd_sts = (s_axi_araddr == `DBS_OFS_STATUS);
	wire rd_cnt = (s_axi_araddr == `DBS_OFS_COUNT);
	wire [31:0] rd_word = rd_ctrl ? {30'h0, ch_en_r} : rd_sts ? sts_word : rd_cnt ? cnt_word : 32'h0;
	wire ar_take = s_axi_arvalid && s_axi_arready;

	// Read channel: one cycle from address to data.
	// Unmapped reads return zero with a slave error.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OK;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (rd_ctrl || rd_sts || rd_cnt) ? RESP_OK : RESP_ERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // dbs_top

// ### rtl/dbs_consts.svh
// Constants of the dual buck supervisor and sequencer.
// What this block does
// - Reset pin low if enabled output unregulated
// - Count 262,144 clocks before releasing reset
// - Single channel: judge only the enabled one
// - Newly enabled channel pulls reset low again
// - Reset pin is open drain, low only
// - Mode pin low: automatic PFM/PWM
// - Mode pin high: forced PWM only
// - Lock to external clock in range
// - Slow external clock: alternate auto and PWM
// - Converters off until lockout releases
// - Enable low: shutdown, reference, oscillator off
// - Enable high: soft-start, then regulation
// - Hot junction: everything off
// - Restart via soft-start once cooled
// - Short: minimum duty, resume when removed
// - Ramp reference, then switch to regular
`ifndef DBS_CONSTS_SVH
`define DBS_CONSTS_SVH
// ****************
// Register map
// ****************
`define DBS_OFS_CTRL 8'h00
`define DBS_OFS_STATUS 8'h04
`define DBS_OFS_COUNT 8'h08
`define DBS_CTRL_RST 2'h3
`define DBS_STS_STATE 0
`define DBS_STS_PG 5
`define DBS_STS_INREG 6
`define DBS_STS_MODE 8
`define DBS_STS_SSDONE 10
// ****************
// Timing
// ****************
`define DBS_PG_DELAY_CYCLES 262144
`define DBS_CLK_KHZ 40000
`define DBS_FSW_KHZ 2250
`define DBS_SYNC_FMAX_KHZ 3000
`define DBS_SYNC_TIMEOUT 64
`define DBS_SS_DIV 16
`endif

// ### rtl/dbs_pkg.sv
// Types shared by the supervisor and its channel helpers.
package dbs_pkg;
	// Sequencer states, one-hot.
	typedef enum logic [4:0] {
		DBS_ST_SHUTDOWN = 5'h01,
		DBS_ST_LOCKOUT = 5'h02,
		DBS_ST_SOFTSTART = 5'h04,
		DBS_ST_RUN = 5'h08,
		DBS_ST_THERMAL = 5'h10
	} dbs_state_t;
	// Switching mode handed to the modulator.
	typedef enum logic [1:0] {
		DBS_MODE_AUTO = 2'h0,
		DBS_MODE_PWM = 2'h1,
		DBS_MODE_SYNC = 2'h2
	} dbs_mode_t;
	// Per-channel status.
	typedef struct packed {
		logic conv_en;
		logic ss_active;
		logic ss_done;
		logic min_duty;
	} dbs_ch_stat_t;
endpackage

// ### rtl/dbs_ch_ctrl.sv
// One converter channel: enable, soft-start ramp and short handling.
`timescale 1ns/1ps
`include "dbs_consts.svh"
module dbs_ch_ctrl #(
	parameter int RAMP_W = 8,
	parameter int SS_DIV = `DBS_SS_DIV
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Control from the sequencer and comparators.
	input wire logic start,
	input wire logic short_det,
	// Channel outputs.
	output logic [RAMP_W-1:0] ramp,
	output dbs_pkg::dbs_ch_stat_t stat
);
	import dbs_pkg::*;
	localparam logic [7:0] DIV_LAST = 8'(SS_DIV - 1);
	logic [7:0] div_r; // Ramp step prescaler.
	wire ramp_full = &ramp; // Ramp at full reference.
	wire step = (div_r == DIV_LAST);
	// The ramp restarts from zero whenever the channel is stopped.
	always_ff @(posedge ref_clk) begin
		if (rst || !start) begin
			div_r <= 8'h00;
			ramp <= '0;
			stat <= '0;
		end else begin
			div_r <= step ? 8'h00 : div_r + 8'h01;
			if (step && !ramp_full) begin
				ramp <= ramp + 1'b1;
			end
			stat.conv_en <= 1'b1;
			stat.ss_done <= ramp_full;
			stat.ss_active <= !ramp_full;
			stat.min_duty <= short_det;
		end
	end
endmodule // dbs_ch_ctrl

// ### rtl/dbs_sync_det.sv
// Decodes the mode/sync pin into a switching mode.
`timescale 1ns/1ps
`include "dbs_consts.svh"
module dbs_sync_det (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Mode/sync pin level.
	input wire logic mode_pin,
	// Decoded mode and sync pulse.
	output dbs_pkg::dbs_mode_t mode,
	output logic sync_pulse
);
	import dbs_pkg::*;
	// Shortest period: 3.0 MHz, rounded up.
	localparam logic [7:0] PMIN = 8'((`DBS_CLK_KHZ + `DBS_SYNC_FMAX_KHZ - 1) / `DBS_SYNC_FMAX_KHZ);
	// Longest period: internal frequency, rounded down.
	localparam logic [7:0] PMAX = 8'(`DBS_CLK_KHZ / `DBS_FSW_KHZ);
	localparam logic [7:0] TOUT = 8'(`DBS_SYNC_TIMEOUT);
	logic prev_r; // Pin one cycle ago.
	logic alt_r; // Alternation phase for slow clocks.
	logic [7:0] per_r; // Cycles since last rising edge.
	wire rise = mode_pin & !prev_r;
	wire in_range = (per_r >= PMIN) && (per_r <= PMAX);
	wire too_slow = (per_r > PMAX);
	// Runs even in shutdown so a clock applied before enable is seen.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_r <= 1'b0;
			alt_r <= 1'b0;
			per_r <= 8'h00;
			mode <= DBS_MODE_AUTO;
			sync_pulse <= 1'b0;
		end else begin
			prev_r <= mode_pin;
			sync_pulse <= 1'b0;
			if (rise) begin
				per_r <= 8'h01;
				if (in_range) begin
					mode <= DBS_MODE_SYNC;
					sync_pulse <= 1'b1;
				end else if (too_slow) begin
					alt_r <= !alt_r;
					mode <= alt_r ? DBS_MODE_PWM : DBS_MODE_AUTO;
				end else begin
					mode <= DBS_MODE_PWM;
				end
			end else if (per_r == TOUT) begin
				mode <= mode_pin ? DBS_MODE_PWM : DBS_MODE_AUTO;
			end else begin
				per_r <= per_r + 8'h01;
			end
		end
	end
endmodule // dbs_sync_det

// ### testbench/dbs_props.sv
// Concurrent checks on the supervisor ports.
`timescale 1ns/1ps
module dbs_props #(
	parameter int PG_DELAY_CYCLES = 20
) (
	// Clock, reset and inputs.
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic enable_in,
	input wire logic input_undervoltage_lockout,
	input wire logic temp_over_180,
	input wire logic [1:0] in_reg,
	input wire logic [1:0] short_det,
	input wire logic mode_pin,
	// Outputs watched.
	input wire logic [1:0] conv_en,
	input wire logic [1:0] min_duty,
	input wire logic [1:0] ref_regular,
	input wire logic ref_on,
	input wire logic osc_on,
	input wire dbs_pkg::dbs_mode_t sw_mode,
	input wire logic sync_pulse,
	input wire logic rst_pin_o,
	input wire logic rst_pin_oe
);
	import dbs_pkg::*;
	// Cycles that every enabled channel has been ramped and in regulation.
	int good_cnt_r;
	// Cycles that the mode pin has kept its level.
	int lvl_cnt_r;
	logic pin_r;
	wire good_w = (conv_en != 2'h0) && ((conv_en & ~(in_reg & ref_regular)) == 2'h0);
	// Saturating counters, so a long steady phase never wraps.
	always_ff @(posedge ref_clk) begin
		good_cnt_r <= (rst || !good_w) ? 0 : ((good_cnt_r < 1000) ? good_cnt_r + 1 : good_cnt_r);
		pin_r <= mode_pin;
		lvl_cnt_r <= (rst || mode_pin != pin_r) ? 0 : ((lvl_cnt_r < 200) ? lvl_cnt_r + 1 : lvl_cnt_r);
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	od_low_a: assert property (rst_pin_o == 1'b0) else $error("reset pin driven high");
	pg_low_a: assert property ((|(conv_en & ~in_reg)) [*3] |-> rst_pin_oe) else $error("reset pin not held");
	pg_early_a: assert property ($fell(rst_pin_oe) |-> good_cnt_r >= PG_DELAY_CYCLES) else $error("early release");
	pg_late_a: assert property (good_cnt_r == PG_DELAY_CYCLES + 6 |-> !rst_pin_oe) else $error("late release");
	new_ch_a: assert property ($rose(conv_en[1]) |-> ##[0:3] rst_pin_oe) else $error("no reset on new channel");
	auto_lvl_a: assert property (lvl_cnt_r == 80 && !mode_pin |-> sw_mode == DBS_MODE_AUTO) else $error("not auto");
	pwm_lvl_a: assert property (lvl_cnt_r == 80 && mode_pin |-> sw_mode == DBS_MODE_PWM) else $error("not pwm");
	sync_mode_a: assert property (sync_pulse |-> ##[0:2] sw_mode == DBS_MODE_SYNC) else $error("sync not taken");
	lockout_hold_a: assert property (!input_undervoltage_lockout [*4] |-> conv_en == 2'h0) else $error("on in lockout");
	shut_off_a: assert property (!enable_in [*4] |-> !osc_on && !ref_on && conv_en == 2'h0) else $error("awake");
	hot_off_a: assert property (temp_over_180 [*4] |-> conv_en == 2'h0) else $error("on while hot");
	short_duty_a: assert property ((short_det[0] && conv_en[0]) [*3] |-> min_duty[0]) else $error("no min duty");
endmodule // dbs_props
bind dbs_top dbs_props #(.PG_DELAY_CYCLES(PG_DELAY_CYCLES)) u_props (
	.ref_clk(ref_clk),
	.rst(rst),
	.enable_in(enable_in),
	.input_undervoltage_lockout(input_undervoltage_lockout),
	.temp_over_180(temp_over_180),
	.in_reg(in_reg),
	.short_det(short_det),
	.mode_pin(mode_pin),
	.conv_en(conv_en),
	.min_duty(min_duty),
	.ref_regular(ref_regular),
	.ref_on(ref_on),
	.osc_on(osc_on),
	.sw_mode(sw_mode),
	.sync_pulse(sync_pulse),
	.rst_pin_o(rst_pin_o),
	.rst_pin_oe(rst_pin_oe)
);

// ### testbench/dbs_host_model.sv
// Host side: reset pin pull-up and mode/sync pin driver.
`timescale 1ns/1ps
module dbs_host_model (
	// Clock.
	input wire logic ref_clk,
	// Steady level, or sync half period in clocks when non-zero.
	input wire logic level,
	input wire logic [7:0] half_per,
	// Open-drain reset pin from the design.
	input wire logic rst_pin_o,
	input wire logic rst_pin_oe,
	// Resolved pins.
	output logic rst_line,
	output logic mode_pin
);
	int cnt_r = 0;
	// The pull-up gives the high level while nobody pulls low.
	assign rst_line = rst_pin_oe ? rst_pin_o : 1'b1;
	initial mode_pin = 1'b0;
	// Square wave when a period is asked for, else the steady level.
	always @(posedge ref_clk) begin
		if (half_per == 8'h00) begin
			mode_pin <= level;
			cnt_r <= 0;
		end else if (cnt_r >= half_per - 1) begin
			mode_pin <= ~mode_pin;
			cnt_r <= 0;
		end else
			cnt_r <= cnt_r + 1;
	end
endmodule // dbs_host_model

// ### testbench/dbs_top_test.sv
// Self-checking bench of the supervisor and sequencer.
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module dbs_top_test;
	import dbs_pkg::*;
	localparam int PG_DELAY_CYCLES = 20;
	// Stimulus.
	logic ref_clk = 0, rst = 1, enable_in = 0, input_undervoltage_lockout = 0, temp_over_180 = 0;
	logic temp_below_140 = 1, level = 0, mode_pin, rst_line;
	logic [1:0] in_reg = 2'h3, short_det = 2'h0;
	logic [7:0] half_per = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	// Design outputs.
	logic [1:0] conv_en, min_duty, ref_regular, s_axi_bresp, s_axi_rresp, rr;
	logic [7:0] ramp0, ramp1;
	logic ref_on, osc_on, sync_pulse, rst_pin_o, rst_pin_oe;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	dbs_mode_t sw_mode;
	int n_fail = 0, checks_done = 0;
	dbs_top #(.PG_DELAY_CYCLES(PG_DELAY_CYCLES)) u_dbs_top (.*);
	dbs_host_model u_dbs_host_model (.*);
	always #12.5 ref_clk = ~ref_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Bounded wait for the reset pin level.
	task automatic wait_line(input logic v);
		for (int i = 0; i < 6000 && rst_line !== v; i++) @(posedge ref_clk);
	endtask
	// One AXI write; each channel released once taken.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic axr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Lockout holds the converters, then soft-start and delayed release.
	task automatic t_boot();
		enable_in <= 1'b1;
		cyc(40);
		`CHK(conv_en, 2'h0)
		input_undervoltage_lockout <= 1'b1;
		cyc(8);
		`CHK({conv_en, ref_regular, rst_line}, 5'h18)
		wait_line(1'b1);
		`CHK({ramp0, ramp1, ref_regular, rst_line}, 19'h7ffff)
	endtask
	// A glitch in mid-count must restart the delay.
	task automatic t_drop();
		in_reg <= 2'h1;
		cyc(4);
		`CHK(rst_line, 1'b0)
		in_reg <= 2'h3;
		cyc(12);
		in_reg <= 2'h1;
		cyc(1);
		in_reg <= 2'h3;
		cyc(PG_DELAY_CYCLES - 2);
		`CHK(rst_line, 1'b0)
		cyc(10);
		`CHK(rst_line, 1'b1)
	endtask
	// One channel alone, then the second enabled again.
	task automatic t_single();
		axw(8'h00, 32'h1);
		`CHK(rr, 2'h0)
		axw(8'h10, 32'h3);
		`CHK(rr, 2'h2)
		in_reg <= 2'h1;
		cyc(PG_DELAY_CYCLES + 10);
		`CHK({conv_en, rst_line}, 3'h3)
		axr(8'h04);
		`CHK({rr, rd[5:0]}, 8'h28)
		axr(8'h0c);
		`CHK({rr, rd}, 34'h200000000)
		in_reg <= 2'h3;
		axw(8'h00, 32'h3);
		cyc(3);
		`CHK(rst_line, 1'b0)
		wait_line(1'b1);
		`CHK(rst_line, 1'b1)
	endtask
	task automatic t_short();
		short_det <= 2'h1;
		cyc(6);
		`CHK(min_duty, 2'h1)
		short_det <= 2'h0;
		cyc(6);
		`CHK(min_duty, 2'h0)
	endtask
	task automatic t_mode(input logic l, input logic [7:0] hp, input dbs_mode_t m);
		int n;
		level <= l;
		half_per <= hp;
		cyc(100);
		n = 0;
		for (int i = 0; i < 160; i++) begin
			@(posedge ref_clk);
			n += (sw_mode == m);
		end
		`CHK(n, 160)
	endtask
	// A slow sync clock alternates between the two modes.
	task automatic t_slow();
		logic [1:0] seen;
		seen = 2'h0;
		half_per <= 8'h0f;
		cyc(100);
		for (int i = 0; i < 120; i++) begin
			@(posedge ref_clk);
			seen |= {sw_mode == DBS_MODE_AUTO, sw_mode == DBS_MODE_PWM};
		end
		`CHK(seen, 2'h3)
	endtask
	// Over-temperature stop and restart once cooled.
	task automatic t_hot();
		temp_over_180 <= 1'b1;
		temp_below_140 <= 1'b0;
		cyc(4);
		`CHK({conv_en, rst_line}, 3'h0)
		temp_over_180 <= 1'b0;
		cyc(20);
		`CHK(conv_en, 2'h0)
		temp_below_140 <= 1'b1;
		cyc(8);
		`CHK({conv_en, ref_regular}, 4'hc)
		wait_line(1'b1);
		`CHK(rst_line, 1'b1)
	endtask
	// Lockout loss, shutdown, then sync clock applied before enable.
	task automatic t_off();
		input_undervoltage_lockout <= 1'b0;
		cyc(4);
		`CHK(conv_en, 2'h0)
		input_undervoltage_lockout <= 1'b1;
		enable_in <= 1'b0;
		half_per <= 8'h08;
		cyc(80);
		`CHK({osc_on, ref_on, conv_en, rst_line}, 5'h0)
		enable_in <= 1'b1;
		cyc(6);
		`CHK({sw_mode, ref_regular}, {DBS_MODE_SYNC, 2'h0})
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_boot();
		t_drop();
		t_single();
		t_short();
		t_mode(1'b0, 8'h00, DBS_MODE_AUTO);
		t_mode(1'b1, 8'h00, DBS_MODE_PWM);
		t_mode(1'b0, 8'h08, DBS_MODE_SYNC);
		t_mode(1'b0, 8'h04, DBS_MODE_PWM);
		t_slow();
		t_hot();
		t_off();
		tally_and_finish();
	end
	// Watchdog, well beyond the three soft-start waits.
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_fail++;
		tally_and_finish();
	end
endmodule // dbs_top_test
